// *** hdl/synth_cal_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module synth_cal_regs
  import synth_cal_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  synth_link_if.dev        link,
  input  wire logic        i_ref_tick,
  input  wire logic        i_counter_reset,
  input  wire logic        i_ref_div_valid,
  input  wire logic [9:0]  i_ref_div,
  output logic [7:0]       o_band_clock_divider,
  output logic [9:0]       o_band_select_timeout,
  output logic [4:0]       o_level_cal_wait,
  output logic [4:0]       o_lock_settle_count,
  output logic [7:0]       o_temp_adc_divider,
  output logic             o_convert_on_write,
  output logic             o_temp_adc_power,
  output logic             o_vco_band_hold,
  output logic [19:0]      o_resync_timeout_count,
  output logic             o_adc_clock_tick,
  output logic             o_adc_convert_start,
  output logic             o_counters_reset,
  output logic             o_vco_band_reset,
  output logic [9:0]       o_ref_div_ratio,
  output logic             o_word_loaded
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  sync2 #(.W(3)) u_sync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_async  ({link.sclk, link.sdata, link.load_en}),
    .o_sync   (pins_s)
  );
  logic sclk_prev_q, sclk_prev_d;
  logic le_prev_q, le_prev_d;
  logic [31:0] shift_q, shift_d;
  logic sclk_rise, le_rise;
  assign sclk_rise = pins_s[2] & ~sclk_prev_q;
  assign le_rise   = pins_s[0] & ~le_prev_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] band_q, band_d, adc_q, adc_d, hold_q, hold_d, resync_q, resync_d;
  logic [9:0]  ref_q, ref_d;
  logic [7:0]  adc_cnt_q, adc_cnt_d;
  logic [9:0]  ref_cnt_q, ref_cnt_d;
  logic        conv_q, conv_d, tick_q, tick_d, loaded_q, loaded_d;

  always_comb
  begin
    sclk_prev_d = pins_s[2];
    le_prev_d   = pins_s[0];
    shift_d     = shift_q;
    band_d      = band_q;
    adc_d       = adc_q;
    hold_d      = hold_q;
    resync_d    = resync_q;
    ref_d       = ref_q;
    conv_d      = 1'b0;
    loaded_d    = 1'b0;
    tick_d      = 1'b0;
    ref_cnt_d   = ref_cnt_q;
    adc_cnt_d   = adc_cnt_q;
    if (sclk_rise)
      shift_d = {shift_q[30:0], pins_s[1]};
    if (le_rise)
    begin
      loaded_d = 1'b1;
      unique case (shift_q[SEL_W-1:0])
        SEL_BAND_CAL: band_d = shift_q;
        SEL_TEMP_ADC:
        begin
          adc_d  = shift_q;
          conv_d = shift_q[CONV_BIT];
        end
        SEL_VCO_HOLD: hold_d = shift_q;
        SEL_RESYNC:   resync_d = shift_q;
        default: ;
      endcase
    end
    if (i_ref_div_valid)
      ref_d = (i_ref_div == 10'h000) ? REF_DIV_DEFAULT : i_ref_div;
    // Reference divide yields the phase detector tick, then ADC divide
    if (i_counter_reset)
    begin
      ref_cnt_d = '0;
      adc_cnt_d = '0;
    end
    else if (i_ref_tick)
    begin
      if (ref_cnt_q + 10'h001 >= ref_q)
      begin
        ref_cnt_d = '0;
        if (adc_q[ADC_PWR_BIT])
        begin
          if (adc_cnt_q + 8'h01 >= adc_q[ADC_DIV_LSB +: 8])
          begin
            adc_cnt_d = '0;
            tick_d    = 1'b1;
          end
          else
            adc_cnt_d = adc_cnt_q + 8'h01;
        end
      end
      else
        ref_cnt_d = ref_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sclk_prev_q <= 1'b0;
      le_prev_q   <= 1'b0;
      shift_q     <= '0;
      band_q      <= '0;
      adc_q       <= '0;
      hold_q      <= '0;
      resync_q    <= '0;
      ref_q       <= REF_DIV_DEFAULT;
      ref_cnt_q   <= '0;
      adc_cnt_q   <= '0;
      conv_q      <= 1'b0;
      tick_q      <= 1'b0;
      loaded_q    <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      le_prev_q   <= le_prev_d;
      shift_q     <= shift_d;
      band_q      <= band_d;
      adc_q       <= adc_d;
      hold_q      <= hold_d;
      resync_q    <= resync_d;
      ref_q       <= ref_d;
      ref_cnt_q   <= ref_cnt_d;
      adc_cnt_q   <= adc_cnt_d;
      conv_q      <= conv_d;
      tick_q      <= tick_d;
      loaded_q    <= loaded_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_band_clock_divider   = band_q[BAND_DIV_LSB +: 8];
  assign o_band_select_timeout  = band_q[BAND_TO_LSB +: 10];
  assign o_level_cal_wait       = band_q[LVL_WAIT_LSB +: 5];
  assign o_lock_settle_count    = band_q[SETTLE_LSB +: 5];
  assign o_temp_adc_divider     = adc_q[ADC_DIV_LSB +: 8];
  assign o_convert_on_write     = adc_q[CONV_BIT];
  assign o_temp_adc_power       = adc_q[ADC_PWR_BIT];
  assign o_vco_band_hold        = hold_q[VCO_HOLD_BIT];
  assign o_resync_timeout_count = resync_q[RESYNC_LSB +: 20];
  assign o_adc_clock_tick       = tick_q;
  // Only powered ADC converts
  assign o_adc_convert_start    = conv_q & adc_q[ADC_PWR_BIT];
  assign o_counters_reset       = i_counter_reset;
  assign o_vco_band_reset       = i_counter_reset & ~hold_q[VCO_HOLD_BIT];
  assign o_ref_div_ratio        = ref_q;
  assign o_word_loaded          = loaded_q;
endmodule
`default_nettype wire

// *** hdl/synth_cal_pkg.sv ***
package synth_cal_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int SEL_W  = 4;
  localparam logic [3:0] SEL_FIXED    = 4'h8;
  localparam logic [3:0] SEL_BAND_CAL = 4'h9;
  localparam logic [3:0] SEL_TEMP_ADC = 4'hA;
  localparam logic [3:0] SEL_VCO_HOLD = 4'hB;
  localparam logic [3:0] SEL_RESYNC   = 4'hC;
  localparam logic [31:0] FIXED_RESERVED_WORD = 32'h15596568;
  // Band and calibration timer fields
  localparam int BAND_DIV_LSB = 24;
  localparam int BAND_TO_LSB  = 14;
  localparam int LVL_WAIT_LSB = 9;
  localparam int SETTLE_LSB   = 4;
  // Temperature ADC control fields
  localparam int ADC_DIV_LSB  = 6;
  localparam int CONV_BIT     = 5;
  localparam int ADC_PWR_BIT  = 4;
  // Bits 23:22 of the reserved span sit at positions 9:8 of this slice
  localparam logic [17:0] ADC_RSVD_VALUE = 18'h00300;
  // VCO hold control
  localparam int VCO_HOLD_BIT = 24;
  localparam logic [27:0] HOLD_RSVD_VALUE = 28'h0061200;
  // Resync timeout
  localparam int RESYNC_LSB = 12;
  localparam logic [7:0] RESYNC_RSVD_VALUE = 8'h5F;
  // Default reference division ratio before programming
  localparam logic [9:0] REF_DIV_DEFAULT = 10'h001;
  // ----------------------------------------------------------------
  // Host link timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int SCLK_DIV    = 4;
endpackage

// *** hdl/synth_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface synth_link_if;
  logic sclk;
  logic sdata;
  logic load_en;
  modport host (output sclk, output sdata, output load_en);
  modport dev  (input sclk, input sdata, input load_en);
endinterface
`default_nettype wire

// *** hdl/sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule
`default_nettype wire

// *** hdl/synth_cal_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module synth_cal_host
  import synth_cal_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  synth_link_if.host       link,
  input  wire logic        i_start,
  input  wire logic [31:0] i_word,
  output logic             o_ready,
  output logic             o_done
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW  = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_LOAD = 4'b1000
  } state_t;
  state_t state_q, state_d;
  logic [31:0] word_q, word_d;
  logic [5:0]  bit_q, bit_d;
  logic [7:0]  div_q, div_d;
  logic        sclk_q, sclk_d, sd_q, sd_d, le_q, le_d, done_q, done_d;
  // Host passes words verbatim; are caller duties
  always_comb
  begin
    state_d = state_q;
    word_d  = word_q;
    bit_d   = bit_q;
    div_d   = (div_q == 8'(SCLK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    sclk_d  = sclk_q;
    sd_d    = sd_q;
    le_d    = 1'b0;
    done_d  = 1'b0;
    unique case (state_q)
      ST_IDLE:
        if (i_start)
        begin
          word_d  = i_word;
          bit_d   = 6'h00;
          div_d   = 8'h00;
          sd_d    = i_word[31];
          state_d = ST_LOW;
        end
      ST_LOW:
        if (div_q == 8'(SCLK_DIV - 1))
        begin
          sclk_d  = 1'b1;
          state_d = ST_HIGH;
        end
      ST_HIGH:
        if (div_q == 8'(SCLK_DIV - 1))
        begin
          sclk_d = 1'b0;
          word_d = {word_q[30:0], 1'b0};
          sd_d   = word_q[30];
          if (bit_q == 6'h1F)
          begin
            le_d    = 1'b1;
            state_d = ST_LOAD;
          end
          else
          begin
            bit_d   = bit_q + 6'h01;
            state_d = ST_LOW;
          end
        end
      ST_LOAD:
      begin
        le_d = 1'b1;
        if (div_q == 8'(SCLK_DIV - 1))
        begin
          le_d    = 1'b0;
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= ST_IDLE;
      word_q  <= '0;
      bit_q   <= '0;
      div_q   <= '0;
      sclk_q  <= 1'b0;
      sd_q    <= 1'b0;
      le_q    <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      word_q  <= word_d;
      bit_q   <= bit_d;
      div_q   <= div_d;
      sclk_q  <= sclk_d;
      sd_q    <= sd_d;
      le_q    <= le_d;
      done_q  <= done_d;
    end
  end
  assign link.sclk    = sclk_q;
  assign link.sdata   = sd_q;
  assign link.load_en = le_q;
  assign o_ready      = (state_q == ST_IDLE);
  assign o_done       = done_q;
endmodule
`default_nettype wire

// *** verif/synth_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module synth_link_checker
(
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic sclk,
  input  wire logic sdata,
  input  wire logic load_en
);
  // ----------------------------------------------------------------
  // Bit counter between strobes
  // ----------------------------------------------------------------
  logic [5:0] bits_q;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      bits_q <= 6'h00;
    else if (load_en)
      bits_q <= 6'h00;
    else if ($rose(sclk))
      bits_q <= bits_q + 6'h01;
  end
  // ----------------------------------------------------------------
  // Wire rules
  // ----------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence high_phase;
    sclk[*4] ##1 !sclk;
  endsequence
  sequence low_phase;
    !sclk[*4];
  endsequence
  sequence strobe_phase;
    load_en[*4] ##1 !load_en;
  endsequence
  sclk_high_len_a: assert property ($rose(sclk) |-> high_phase)
    else $error("serial clock high phase wrong length");
  sclk_low_len_a: assert property ($fell(sclk) |-> low_phase)
    else $error("serial clock low phase too short");
  data_stable_a: assert property (sclk |-> $stable(sdata))
    else $error("data moved while serial clock high");
  strobe_len_a: assert property ($rose(load_en) |-> strobe_phase)
    else $error("load strobe wrong length");
  strobe_quiet_a: assert property (load_en |-> !sclk)
    else $error("serial clock toggled during load strobe");
  word_bits_a: assert property ($rose(load_en) |-> bits_q == 6'h20)
    else $error("word not 32 bits at load strobe");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import synth_cal_pkg::*;
  logic        i_clock, i_arst_n, i_start, i_ref_tick, i_counter_reset, i_ref_div_valid;
  logic [31:0] i_word, cap_q;
  logic [9:0]  i_ref_div, ratio, bto;
  logic        o_ready, o_done, tick, cstart, cres, vres, loaded, conv, pwr, hold;
  logic [7:0]  bdiv, adiv;
  logic [4:0]  lwait, settle;
  logic [19:0] resync;
  int          errors, num_checks, t0;
  int          conv_n = 0;
  int          tick_n = 0;
  int          cyc = 0;
  int          load_n = 0;
  synth_link_if u_synth_link_if();
  synth_cal_host u_synth_cal_host (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(u_synth_link_if), .i_start(i_start), .i_word(i_word), .o_ready(o_ready),
    .o_done(o_done));
  synth_cal_regs u_synth_cal_regs (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .link(u_synth_link_if), .i_ref_tick(i_ref_tick), .i_counter_reset(i_counter_reset),
    .i_ref_div_valid(i_ref_div_valid), .i_ref_div(i_ref_div),
    .o_band_clock_divider(bdiv), .o_band_select_timeout(bto), .o_level_cal_wait(lwait),
    .o_lock_settle_count(settle), .o_temp_adc_divider(adiv), .o_convert_on_write(conv),
    .o_temp_adc_power(pwr), .o_vco_band_hold(hold), .o_resync_timeout_count(resync),
    .o_adc_clock_tick(tick), .o_adc_convert_start(cstart), .o_counters_reset(cres),
    .o_vco_band_reset(vres), .o_ref_div_ratio(ratio), .o_word_loaded(loaded));
  synth_link_checker u_synth_link_checker (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .sclk(u_synth_link_if.sclk), .sdata(u_synth_link_if.sdata),
    .load_en(u_synth_link_if.load_en));
  // ----------------------------------------------------------------
  // Clock, reference ticks and monitors
  // ----------------------------------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(negedge i_clock)
  begin
    cyc <= cyc + 1;
    i_ref_tick <= (cyc % 4 == 0);
  end
  always @(posedge u_synth_link_if.sclk) cap_q <= {cap_q[30:0], u_synth_link_if.sdata};
  always @(posedge i_clock)
  begin
    if (cstart === 1'b1) conv_n <= conv_n + 1;
    if (tick === 1'b1) tick_n <= tick_n + 1;
    if (loaded === 1'b1) load_n <= load_n + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 600) begin @(negedge i_clock); n++; end
    i_word = w;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 600) begin @(negedge i_clock); n++; end
    if (n >= 600) begin errors++; final_report(); end
    repeat (10) @(negedge i_clock);
    check("wire_word", cap_q, w);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {i_arst_n, i_start, i_counter_reset, i_ref_div_valid} = 4'h0;
    {i_word, i_ref_div, errors, num_checks, t0} = '0;
    repeat (3) @(negedge i_clock);
    i_arst_n = 1'b1;
    check("ref_ratio", ratio, 32'h1);
    send({8'hA5, 10'h3FF, 5'h1F, 5'h0A, SEL_BAND_CAL});
    check("band_div", bdiv, 32'hA5);
    check("band_to", bto, 32'h3FF);
    check("lvl_wait", lwait, 32'h1F);
    check("settle", settle, 32'h0A);
    send(FIXED_RESERVED_WORD);
    check("band_div_kept", bdiv, 32'hA5);
    send({ADC_RSVD_VALUE, 8'h02, 2'b11, SEL_TEMP_ADC});
    check("adc_div", adiv, 32'h02);
    check("conv_pwr", {conv, pwr}, 32'h3);
    check("conv_once", conv_n, 32'h1);
    t0 = tick_n;
    repeat (400) @(negedge i_clock);
    check("adc_rate", (tick_n - t0 >= 49 && tick_n - t0 <= 51), 32'h1);
    send({ADC_RSVD_VALUE, 8'h02, 2'b01, SEL_TEMP_ADC});
    check("conv_off", conv_n, 32'h1);
    send({28'h0161200, SEL_VCO_HOLD});
    i_counter_reset = 1'b1;
    @(negedge i_clock);
    check("hold_rst", {hold, cres, vres}, 32'h6);
    send({HOLD_RSVD_VALUE, SEL_VCO_HOLD});
    check("nohold_rst", {hold, cres, vres}, 32'h3);
    i_counter_reset = 1'b0;
    send({20'h00017, RESYNC_RSVD_VALUE, SEL_RESYNC});
    check("resync", resync, 32'h17);
    i_ref_div = 10'h003;
    i_ref_div_valid = 1'b1;
    @(negedge i_clock);
    i_ref_div_valid = 1'b0;
    repeat (4) @(negedge i_clock);
    check("ref_ratio_set", ratio, 32'h3);
    check("words_loaded", load_n, 32'h7);
    final_report();
  end
endmodule
`default_nettype wire
